// ---- hw/cae_params.svh ----
// Timing counts and reset values for the alert event control block.
// Assumes mclk at 50 MHz and a 32.768 kHz slow clock.
`ifndef CAE_PARAMS_SVH
`define CAE_PARAMS_SVH
`define CAE_MCLK_KHZ      50000
`define CAE_FAST_KHZ      3580
`define CAE_INIT_PERIODS  100
`define CAE_INIT_CYCLES   ((`CAE_INIT_PERIODS * `CAE_MCLK_KHZ) / `CAE_FAST_KHZ)
`define CAE_SLOW_HZ       32768
`define CAE_SEC_PER_MIN   60
`define CAE_FLAGS_RST     8'h00
`define CAE_STATUS_RST    8'h00
`endif

// ---- hw/cae_pkg.sv ----
// Types shared by the alert event control block.
// Assumes cae_params.svh holds every count and reset value.
package cae_pkg;
    typedef struct packed {
        logic fast_osc_enable;
        logic tone_enable;
        logic fsk_enable;
        logic polarity_irq_enable;
        logic irq_active_low;
        logic timebase_enable;
        logic timebase_rate_select;
    } cae_mode_t;

    typedef struct packed {
        logic tone_hit;
        logic level_low;
        logic fsk_byte_done;
    } cae_det_t;

    typedef struct packed {
        logic       line_sense_zero;
        logic       line_sense_one;
        logic       battery_low;
        logic [4:0] zero;
    } cae_status_t;

    typedef struct packed {
        logic min_tick;
        logic sec_tick;
        logic fsk_byte;
        logic level_low;
        logic pol_zero;
        logic pol_one;
        logic tone;
        logic spare;
    } cae_flags_t;

    typedef enum logic [1:0] {
        CAE_INIT_RUN  = 2'b01,
        CAE_INIT_DONE = 2'b10
    } cae_init_t;
endpackage : cae_pkg

// ---- hw/cae_top.sv ----
// Event, power-down and interrupt control of an alert-tone receiver.
// Assumes a detector datapath on mclk and a free-running slow clock.
// Notes on behaviour
// - Clearing fast oscillator enable stops fast clock and converter.
// - Line sense comparators and slow clock always keep running.
// - Tone, FSK and fast oscillator have independent enables.
// - Polarity interrupts only while polarity interrupt enable is set.
// - Line sense comparator outputs readable in status bits 7 and 6.
// - Polarity interrupts come from the slow clock domain only.
// - Detector initialisation within 100 fast clock periods after reset or enable.
// - Detected dual tone sets flag bit 1 and raises interrupt.
// - Tone interrupts blocked while input level is below threshold.
// - Battery below reference reads as status bit 5 set.
// - Interrupt output selectable active high or active low.
// - Second or minute timebase derived from the slow clock.
// - Polarity, FSK byte, tone and timebase events drive the interrupt.
// - Controller reads status and writes options over the parallel status and mode_control ports.
// - Reading the flag register clears all flags but bit 4, which follows the level input; hardware sets them.
// - Interrupt active high by default, low by mode bit, else released.
// - Sense zero interrupts on falling, sense one on rising.
// - Rate select set gives seconds and minutes, clear gives minutes only.
`timescale 1ns/10ps
`include "cae_params.svh"
module cae_top #(
    parameter int SLOW_HZ = `CAE_SLOW_HZ
) (
    input  wire logic            mclk,
    input  wire logic            sys_rst,
    input  wire logic            slow_clk,
    input  wire logic            line_sense_zero,
    input  wire logic            line_sense_one,
    input  wire logic            battery_low_input,
    input  cae_pkg::cae_mode_t   mode_control,
    input  cae_pkg::cae_det_t    detector,
    input  wire logic            flag_read,
    output logic                 fast_clk_run,
    output logic                 adc_run,
    output logic                 detector_init,
    output cae_pkg::cae_status_t status,
    output cae_pkg::cae_flags_t  interrupt_flag_register,
    output logic                 irq_o,
    output logic                 irq_oe
);
    localparam logic [15:0] INIT_LAST = 16'(`CAE_INIT_CYCLES - 1);
    localparam logic [15:0] SEC_LAST  = 16'(SLOW_HZ - 1);
    localparam logic [5:0]  MIN_LAST  = 6'(`CAE_SEC_PER_MIN - 1);

    // Slow domain: sense sync, polarity edges, timebase
    logic [1:0]  ls_s1_q, ls_s2_q, ls_prev_q;
    logic [2:0]  cfg_s1_q, cfg_s2_q;
    logic [15:0] sec_cnt_q, sec_cnt_d;
    logic [5:0]  min_cnt_q, min_cnt_d;
    logic [3:0]  tog_q, tog_d;
    logic [2:0]  arm_q;
    logic        line_sense_zero_ev, line_sense_one_ev, sec_wrap, min_wrap;

    always_comb
    begin
        line_sense_zero_ev   = ls_prev_q[0] & ~ls_s2_q[0] & cfg_s2_q[2] & arm_q[2];
        line_sense_one_ev   = ~ls_prev_q[1] & ls_s2_q[1] & cfg_s2_q[2] & arm_q[2];
        sec_wrap  = sec_cnt_q == SEC_LAST;
        min_wrap  = sec_wrap && min_cnt_q == MIN_LAST;
        sec_cnt_d = sec_wrap ? 16'h0000 : sec_cnt_q + 16'h0001;
        min_cnt_d = min_wrap ? 6'h00 : (sec_wrap ? min_cnt_q + 6'h01 : min_cnt_q);
        if (!cfg_s2_q[1])
        begin
            sec_cnt_d = 16'h0000;
            min_cnt_d = 6'h00;
        end
        tog_d    = tog_q;
        tog_d[0] = tog_q[0] ^ line_sense_zero_ev;
        tog_d[1] = tog_q[1] ^ line_sense_one_ev;
        tog_d[2] = tog_q[2] ^ (cfg_s2_q[1] & sec_wrap & cfg_s2_q[0]);
        tog_d[3] = tog_q[3] ^ (cfg_s2_q[1] & min_wrap);
    end

    always_ff @(posedge slow_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ls_s1_q   <= 2'h0;
            ls_s2_q   <= 2'h0;
            ls_prev_q <= 2'h0;
            cfg_s1_q  <= 3'h0;
            cfg_s2_q  <= 3'h0;
            sec_cnt_q <= 16'h0000;
            min_cnt_q <= 6'h00;
            tog_q     <= 4'h0;
            arm_q     <= 3'h0;
        end
        else
        begin
            ls_s1_q   <= {line_sense_one, line_sense_zero};
            ls_s2_q   <= ls_s1_q;
            ls_prev_q <= ls_s2_q;
            cfg_s1_q  <= {mode_control.polarity_irq_enable, mode_control.timebase_enable,
                          mode_control.timebase_rate_select};
            cfg_s2_q  <= cfg_s1_q;
            sec_cnt_q <= sec_cnt_d;
            min_cnt_q <= min_cnt_d;
            tog_q     <= tog_d;
            arm_q     <= {arm_q[1:0], 1'b1};
        end
    end

    // Fast domain: crossings, status, power control
    logic [3:0] tg_s1_q, tg_s2_q, tg_prev_q, ev;
    logic [2:0] st_s1_q, st_s2_q;
    cae_pkg::cae_status_t status_q, status_d;
    logic       run_q, ten_prev_q;

    always_comb
    begin
        ev       = tg_s2_q ^ tg_prev_q;
        status_d = cae_pkg::cae_status_t'(`CAE_STATUS_RST);
        status_d.line_sense_zero = st_s2_q[0];
        status_d.line_sense_one  = st_s2_q[1];
        status_d.battery_low     = st_s2_q[2];
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            tg_s1_q    <= 4'h0;
            tg_s2_q    <= 4'h0;
            tg_prev_q  <= 4'h0;
            st_s1_q    <= 3'h0;
            st_s2_q    <= 3'h0;
            status_q   <= cae_pkg::cae_status_t'(`CAE_STATUS_RST);
            run_q      <= 1'b0;
            ten_prev_q <= 1'b0;
        end
        else
        begin
            tg_s1_q    <= tog_q;
            tg_s2_q    <= tg_s1_q;
            tg_prev_q  <= tg_s2_q;
            st_s1_q    <= {battery_low_input, line_sense_one, line_sense_zero};
            st_s2_q    <= st_s1_q;
            status_q   <= status_d;
            run_q      <= mode_control.fast_osc_enable;
            ten_prev_q <= mode_control.tone_enable;
        end
    end

    // Detector initialisation after reset or tone enable
    cae_pkg::cae_init_t init_q, init_d;
    logic [15:0]        icnt_q, icnt_d;

    always_comb
    begin
        init_d = init_q;
        icnt_d = icnt_q;
        unique case (init_q)
            cae_pkg::CAE_INIT_RUN:
            begin
                icnt_d = icnt_q + 16'h0001;
                if (icnt_q == INIT_LAST)
                begin
                    init_d = cae_pkg::CAE_INIT_DONE;
                end
            end
            cae_pkg::CAE_INIT_DONE:
            begin
                icnt_d = 16'h0000;
            end
            default:
            begin
                init_d = cae_pkg::CAE_INIT_RUN;
                icnt_d = 16'h0000;
            end
        endcase
        if (mode_control.tone_enable && !ten_prev_q)
        begin
            init_d = cae_pkg::CAE_INIT_RUN;
            icnt_d = 16'h0000;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            init_q <= cae_pkg::CAE_INIT_RUN;
            icnt_q <= 16'h0000;
        end
        else
        begin
            init_q <= init_d;
            icnt_q <= icnt_d;
        end
    end

    // Interrupt flags and request pin
    cae_pkg::cae_flags_t flags_q, flags_d, pend;
    logic                irq_o_q, irq_o_d, irq_oe_q, irq_oe_d, det_live;

    always_comb
    begin
        det_live  = mode_control.fast_osc_enable && init_q == cae_pkg::CAE_INIT_DONE;
        flags_d   = flag_read ? cae_pkg::cae_flags_t'(`CAE_FLAGS_RST) : flags_q;
        flags_d.level_low = detector.level_low;
        flags_d.pol_zero  = flags_d.pol_zero | (ev[0] & mode_control.polarity_irq_enable);
        flags_d.pol_one   = flags_d.pol_one | (ev[1] & mode_control.polarity_irq_enable);
        flags_d.sec_tick  = flags_d.sec_tick | ev[2];
        flags_d.min_tick  = flags_d.min_tick | ev[3];
        flags_d.tone      = flags_d.tone | (detector.tone_hit & mode_control.tone_enable & det_live
                                            & ~detector.level_low);
        flags_d.fsk_byte  = flags_d.fsk_byte | (detector.fsk_byte_done & mode_control.fsk_enable
                                                & mode_control.fast_osc_enable);
        pend           = flags_d;
        pend.level_low = 1'b0;
        irq_oe_d       = |pend;
        irq_o_d        = mode_control.irq_active_low ? ~irq_oe_d : irq_oe_d;
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            flags_q  <= cae_pkg::cae_flags_t'(`CAE_FLAGS_RST);
            irq_o_q  <= 1'b0;
            irq_oe_q <= 1'b0;
        end
        else
        begin
            flags_q  <= flags_d;
            irq_o_q  <= irq_o_d;
            irq_oe_q <= irq_oe_d;
        end
    end

    assign fast_clk_run            = run_q;
    assign adc_run                 = run_q;
    assign detector_init           = init_q[0];
    assign status                  = status_q;
    assign interrupt_flag_register = flags_q;
    assign irq_o                   = irq_o_q;
    assign irq_oe                  = irq_oe_q;

    // Checks
    sequence s_tone_rise;
        !mode_control.tone_enable ##1 mode_control.tone_enable;
    endsequence

    // Check helper: length of the current initialisation run
    logic [15:0] init_age_q, init_age_d;
    logic        tone_seen_q;

    always_comb
    begin
        init_age_d = 16'h0000;
        if (detector_init && !(mode_control.tone_enable && !tone_seen_q))
        begin
            init_age_d = init_age_q + 16'h0001;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            init_age_q  <= 16'h0000;
            tone_seen_q <= 1'b0;
        end
        else
        begin
            init_age_q  <= init_age_d;
            tone_seen_q <= mode_control.tone_enable;
        end
    end

    a_init_start: assert property (@(posedge mclk) disable iff (sys_rst)
        s_tone_rise |=> detector_init)
        else $error("detector init not restarted");

    a_init_bounded: assert property (@(posedge mclk) disable iff (sys_rst)
        detector_init |-> init_age_q <= INIT_LAST)
        else $error("detector init too long");

    a_tone_sets: assert property (@(posedge mclk) disable iff (sys_rst)
        detector.tone_hit && mode_control.tone_enable && mode_control.fast_osc_enable && !detector_init
        && !detector.level_low |=> interrupt_flag_register.tone && irq_oe)
        else $error("tone did not set flag");

    a_tone_blocked: assert property (@(posedge mclk) disable iff (sys_rst)
        detector.tone_hit && detector.level_low && (flag_read || !interrupt_flag_register.tone)
        |=> !interrupt_flag_register.tone)
        else $error("tone flag set at low level");

    a_read_clears: assert property (@(posedge mclk) disable iff (sys_rst)
        flag_read && ev == 4'h0 && !detector.tone_hit && !detector.fsk_byte_done
        |=> {interrupt_flag_register[7:5], interrupt_flag_register[3:0]} == 7'h00)
        else $error("flags not cleared by read");

    a_irq_level: assert property (@(posedge mclk) disable iff (sys_rst)
        irq_oe |-> irq_o != $past(mode_control.irq_active_low))
        else $error("irq polarity wrong");

    a_irq_release: assert property (@(posedge mclk) disable iff (sys_rst)
        irq_oe == ({interrupt_flag_register[7:5], interrupt_flag_register[3:0]} != 7'h00))
        else $error("irq not tied to flags");

    a_power_down: assert property (@(posedge mclk) disable iff (sys_rst)
        !mode_control.fast_osc_enable |=> !fast_clk_run && !adc_run)
        else $error("fast clock still running");

    a_battery_bit: assert property (@(posedge mclk) disable iff (sys_rst)
        battery_low_input [*4] |=> status.battery_low)
        else $error("battery low not shown");

    a_pol_edge: assert property (@(posedge slow_clk) disable iff (sys_rst)
        ls_prev_q[0] && !ls_s2_q[0] && cfg_s2_q[2] |=> tog_q[0] != $past(tog_q[0]))
        else $error("sense zero fall missed");

    a_tb_reset: assert property (@(posedge slow_clk) disable iff (sys_rst)
        !cfg_s2_q[1] |=> sec_cnt_q == 16'h0000 && tog_q[3:2] == $past(tog_q[3:2]))
        else $error("timebase ran while off");
endmodule : cae_top

// ---- dv/cae_mcu_model.sv ----
// Controller side model: reads the flag register and sees the irq pin.
// Assumes a pull resistor on the irq line, down by default.
`timescale 1ns/10ps
module cae_mcu_model #(
    parameter bit PULL_UP = 1'b0
) (
    input  wire logic mclk,
    input  wire logic irq_o,
    input  wire logic irq_oe,
    output logic      flag_read,
    output logic      irq_pin
);
    // Released pin goes to the pull level
    assign irq_pin = irq_oe ? irq_o : PULL_UP;

    initial flag_read = 1'b0;

    // One-cycle read pulse, raised just after an edge
    task automatic read_flags;
        @(posedge mclk);
        #1 flag_read = 1'b1;
        @(posedge mclk);
        #1 flag_read = 1'b0;
        @(posedge mclk);
        #1;
    endtask : read_flags
endmodule : cae_mcu_model

// ---- dv/tb_top.sv ----
// Self-checking bench for the alert event control block.
// Assumes SLOW_HZ of 16 so that ticks come quickly.
`timescale 1ns/10ps
module tb_top;
    logic                   mclk     = 1'b0;
    logic                   slow_clk = 1'b0;
    logic                   sys_rst  = 1'b1;
    logic                   s0       = 1'b0;
    logic                   s1       = 1'b0;
    logic                   bat      = 1'b0;
    cae_pkg::cae_mode_t     mode     = '0;
    cae_pkg::cae_det_t      det      = '0;
    logic                   rd;
    logic                   run;
    logic                   adc;
    logic                   init;
    cae_pkg::cae_status_t   st;
    cae_pkg::cae_flags_t    flg;
    logic                   irq_o;
    logic                   irq_oe;
    logic                   pin;
    int                     n_fail      = 0;
    int                     comparisons = 0;

    always #10 mclk = ~mclk;
    always #16 slow_clk = ~slow_clk;

    cae_top #(.SLOW_HZ(16)) uut (
        .mclk(mclk), .sys_rst(sys_rst), .slow_clk(slow_clk),
        .line_sense_zero(s0), .line_sense_one(s1), .battery_low_input(bat),
        .mode_control(mode), .detector(det), .flag_read(rd),
        .fast_clk_run(run), .adc_run(adc), .detector_init(init),
        .status(st), .interrupt_flag_register(flg),
        .irq_o(irq_o), .irq_oe(irq_oe)
    );

    cae_mcu_model mcu (
        .mclk(mclk), .irq_o(irq_o), .irq_oe(irq_oe), .flag_read(rd), .irq_pin(pin)
    );

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic final_report;
        if (n_fail == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : final_report

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : cyc

    task automatic wait_flag(input logic [7:0] m, input int bound);
        int i;
        for (i = 0; i < bound && (flg & m) === 8'h00; i++)
            cyc(1);
        if (i == bound)
        begin
            n_fail++;
            $display("[FAIL] wait_flag expected %h seen %h", m, flg);
            final_report();
        end
    endtask : wait_flag

    task automatic wait_init;
        int i;
        for (i = 0; i < 1500 && init !== 1'b0; i++)
            cyc(1);
        chk("init_time", 8'h01, 8'(i <= 1396));
        if (i == 1500)
            final_report();
    endtask : wait_init

    task automatic pulse(input bit tone);
        det.tone_hit      = tone;
        det.fsk_byte_done = !tone;
        cyc(1);
        det = '{tone_hit: 1'b0, level_low: det.level_low, fsk_byte_done: 1'b0};
        cyc(2);
    endtask : pulse

    initial
    begin
        cyc(5);
        sys_rst = 1'b0;
        chk("init_rst", 8'h01, {7'h0, init});
        chk("flags_rst", 8'h00, flg);
        wait_init();
        mode.fast_osc_enable = 1'b1;
        cyc(2);
        chk("run_on", 8'h03, {6'h0, run, adc});
        mode.tone_enable = 1'b1;
        cyc(2);
        chk("init_en", 8'h01, {7'h0, init});
        wait_init();
        pulse(1'b1);
        chk("tone_flag", 8'h02, flg);
        chk("irq_high", 8'h07, {5'h0, irq_oe, irq_o, pin});
        mcu.read_flags();
        chk("flags_clr", 8'h00, {flg[7:1], irq_oe});
        det.level_low = 1'b1;
        pulse(1'b1);
        chk("tone_low", 8'h10, flg);
        det.level_low = 1'b0;
        mode.irq_active_low = 1'b1;
        mode.fsk_enable = 1'b1;
        pulse(1'b0);
        chk("fsk_flag", 8'h20, flg);
        chk("irq_low", 8'h04, {5'h0, irq_oe, irq_o, pin});
        mode.irq_active_low = 1'b0;
        mode.tone_enable = 1'b0;
        mode.fsk_enable = 1'b0;
        cyc(1);
        mcu.read_flags();
        mode.fast_osc_enable = 1'b0;
        cyc(2);
        chk("run_off", 8'h00, {6'h0, run, adc});
        s0 = 1'b1;
        s1 = 1'b1;
        bat = 1'b1;
        cyc(20);
        chk("status", 8'he0, st);
        chk("pol_off", 8'h00, flg);
        mode.polarity_irq_enable = 1'b1;
        cyc(3);
        s0 = 1'b0;
        wait_flag(8'h08, 40);
        chk("pol_zero", 8'h08, flg);
        mcu.read_flags();
        s1 = 1'b0;
        cyc(20);
        chk("pol_fall", 8'h00, flg);
        s1 = 1'b1;
        wait_flag(8'h04, 40);
        chk("pol_one", 8'h04, flg);
        mcu.read_flags();
        mode.timebase_enable = 1'b1;
        mode.timebase_rate_select = 1'b1;
        wait_flag(8'h40, 80);
        chk("sec_tick", 8'h40, flg);
        mode.timebase_rate_select = 1'b0;
        cyc(10);
        mcu.read_flags();
        wait_flag(8'h80, 1700);
        chk("min_tick", 8'h80, flg);
        final_report();
    end
endmodule : tb_top
